// ### design/gpc_chg.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-change detector for one group of pins.
module gpc_chg #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] pin_sync,
  input  wire logic [W-1:0] mask,
  input  wire logic         enable,
  output logic              hit
);

  // The whole state: pin levels one clock earlier.
  typedef struct packed {
    logic [W-1:0] prev;
  } gpc_chg_st_t;

  gpc_chg_st_t st;       // Registered state.
  gpc_chg_st_t next_st;  // Next state.

  // Remember the level for the next comparison.
  always_comb
  begin
    next_st = st;
    next_st.prev = pin_sync;
  end

  // Register the state.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  // A masked pin that moved, with the group on, is a hit.
  assign hit = enable & (|((pin_sync ^ st.prev) & mask));

endmodule
`default_nettype wire

// ### design/gpc_pkg.sv
`default_nettype none
// Shared constants and carriers for the pin-change GPIO block.
package gpc_pkg;

  // Three ports; each port also forms one pin-change group.
  localparam int NPORT = 3;
  // Total number of pins over all ports.
  localparam int NPIN = 18;
  // Pin count of each port: low, mid and high group.
  localparam int PORT_W [0:NPORT-1] = '{8, 4, 6};
  // First global pin index of each port.
  localparam int PORT_LSB [0:NPORT-1] = '{0, 8, 12};
  // Width of the I/O register address.
  localparam int ADDR_W = 6;

  // Base address of each port's four registers.
  localparam logic [5:0] PORT_BASE [0:NPORT-1] =
    '{6'h00, 6'h04, 6'h14};
  // Register order inside one port block.
  localparam logic [1:0] OFS_PIN   = 2'h0;
  localparam logic [1:0] OFS_DIR   = 2'h1;
  localparam logic [1:0] OFS_LATCH = 2'h2;
  localparam logic [1:0] OFS_PULL  = 2'h3;

  // Pin-change mask registers, one per group.
  localparam logic [5:0] MASK_ADDR [0:NPORT-1] =
    '{6'h09, 6'h0A, 6'h1A};
  // Writable bits of each mask register.
  localparam logic [7:0] MASK_VALID [0:NPORT-1] =
    '{8'hFF, 8'h0F, 8'h3F};
  // Group flag register and global mask register.
  localparam logic [5:0] FLAG_ADDR = 6'h0B;
  localparam logic [5:0] GMASK_ADDR = 6'h0C;
  // Break-before-make control, one bit per port.
  localparam logic [5:0] BBM_ADDR = 6'h18;
  // Lowest bit of the group fields in flag and mask registers.
  localparam int GRP_LSB = 4;
  // Reset value of every register.
  localparam logic [7:0] REG_RST = 8'h00;

  // One register access from the core side.
  typedef struct packed {
    logic              wr;       // Full byte write.
    logic              rd;       // Byte read.
    logic              bit_set;  // Single-bit set.
    logic              bit_clr;  // Single-bit clear.
    logic [ADDR_W-1:0] addr;     // Register address.
    logic [2:0]        bit_sel;  // Bit number for bit operations.
    logic [7:0]        wdata;    // Write data.
  } gpc_io_req_t;

  // Write strobes toward one port.
  typedef struct packed {
    logic       latch_we;   // Load output latch.
    logic       dir_we;     // Load direction.
    logic       pull_we;    // Load pull-up enable.
    logic       toggle_we;  // Toggle latch where data is one.
    logic [7:0] data;       // Effective write data.
  } gpc_port_wr_t;

  // Register contents of one port, zero-extended.
  typedef struct packed {
    logic [7:0] latch;  // Output latch.
    logic [7:0] dir;    // Direction.
    logic [7:0] pull;   // Pull-up enable.
    logic [7:0] pin;    // Synchronised pin level.
  } gpc_port_view_t;

endpackage
`default_nettype wire

// ### design/gpc_port.sv
`timescale 1ns/1ps
`default_nettype none
// Register bits and pin drivers of one GPIO port.
module gpc_port #(
  parameter int W = 8
) (
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire gpc_pkg::gpc_port_wr_t   wr,
  input  wire logic                    bbm,
  input  wire logic [W-1:0]            pin_in,
  output gpc_pkg::gpc_port_view_t      view,
  output logic [W-1:0]                 pin_out,
  output logic [W-1:0]                 pin_oe,
  output logic [W-1:0]                 pin_pullup
);

  // The whole port state.
  typedef struct packed {
    logic [W-1:0] latch;  // Output latch.
    logic [W-1:0] dir;    // Direction, one is output.
    logic [W-1:0] pull;   // Pull-up enable.
    logic [W-1:0] oe;     // Driver enable seen on the pins.
    logic [W-1:0] s1;     // First synchroniser stage.
    logic [W-1:0] s2;     // Second stage, the pin input value.
  } gpc_port_st_t;

  gpc_port_st_t st;       // Registered state.
  gpc_port_st_t next_st;  // Next state.

  // Every bit is handled on its own, so a pin lent to another
  // function never disturbs its neighbours.
  always_comb
  begin
    next_st = st;
    // Two flops stand in for the latch plus flop sampler.
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    // A full write loads the latch; a toggle flips only ones.
    if (wr.latch_we)
      next_st.latch = wr.data[W-1:0];
    else if (wr.toggle_we)
      next_st.latch = st.latch ^ wr.data[W-1:0];
    if (wr.dir_we)
      next_st.dir = wr.data[W-1:0];
    if (wr.pull_we)
      next_st.pull = wr.data[W-1:0];
    // An input to output turn stays off one clock under bbm;
    // output to input takes effect at once.
    next_st.oe = next_st.dir
               & ~({W{bbm}} & next_st.dir & ~st.dir);
  end

  // Reset clears the driver enables and pull-ups at once.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  // Pins follow the registered latch, enable and pull-up.
  assign pin_out    = st.latch;
  assign pin_oe     = st.oe;
  assign pin_pullup = st.pull;

  // Register view for the read path, one driver for the whole struct.
  // Field order is latch, direction, pull-up, then pin level.
  assign view = {8'(st.latch), 8'(st.dir), 8'(st.pull), 8'(st.s2)};

endmodule
`default_nettype wire

// ### design/gpc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Top of the GPIO block with pin-change masks.
// Software reaches all registers over the byte-wide I/O port.
// Reads answer one clock after the request.

// Function
// - High group pins need mask and enable.
// - Mid group pins need mask and enable.
// - Low group pins need mask and enable.
// - Mid mask upper nibble reads zero.
// - Four registers per port.
// - Writing one to pin input toggles latch.
// - Single-bit set and clear touch one bit.
// - Direction one means output.
// - Output pin follows latch bit.
// - Pull-up follows its bit, any direction.
// - Reset tri-states pins without clock.
// - Break-before-make gives one off clock.
// - Break-before-make applies to whole port.
// - No off gap from output to input.
// - Other pins unaffected by alternate functions.
// - Pin input read through two-stage sampler.
// - Enabled pin change sets group flag.
module gpc_top (
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  input  wire gpc_pkg::gpc_io_req_t        io,
  input  wire logic [gpc_pkg::NPORT-1:0]   irq_ack,
  input  wire logic [gpc_pkg::NPIN-1:0]    pin_in,
  output logic [7:0]                       io_rdata,
  output logic [gpc_pkg::NPIN-1:0]         pin_out,
  output logic [gpc_pkg::NPIN-1:0]         pin_oe,
  output logic [gpc_pkg::NPIN-1:0]         pin_pullup,
  output logic [gpc_pkg::NPORT-1:0]        change_irq
);

  // Local shorthand for the port count.
  localparam int NP = gpc_pkg::NPORT;

  // The whole state of the top level.
  typedef struct packed {
    logic [NP-1:0][7:0] mask;    // Pin-change masks per group.
    logic [NP-1:0]      enable;  // Group enables.
    logic [NP-1:0]      flag;    // Group flags.
    logic [NP-1:0]      bbm;     // Break-before-make per port.
    logic [7:0]         rdata;   // Read answer.
    logic [NP-1:0]      irq;     // Group requests.
  } gpc_top_st_t;

  gpc_top_st_t st;       // Registered state.
  gpc_top_st_t next_st;  // Next state.

  // Per-port carriers between the top and the ports.
  gpc_pkg::gpc_port_wr_t   port_wr   [0:NP-1];
  gpc_pkg::gpc_port_view_t port_view [0:NP-1];
  // Change hit of each group.
  logic [NP-1:0] hit;

  // Decoded access, shared by the read and write paths.
  logic [7:0] cur;      // Present value at the address.
  logic       w1_reg;   // Address holds write-one bits.
  logic [7:0] bmask;    // One-hot bit operation mask.
  logic       wr_any;   // Any kind of write.
  logic [7:0] wd;       // Effective write data.

  // Read mux: the present value of the addressed register.
  always_comb
  begin
    cur = gpc_pkg::REG_RST;
    w1_reg = 1'b0;
    if (io.addr == gpc_pkg::FLAG_ADDR)
    begin
      // Group flags sit in bits 6:4 of the byte, from GRP_LSB up.
      cur[gpc_pkg::GRP_LSB +: NP] = st.flag;
      w1_reg = 1'b1;
    end
    else if (io.addr == gpc_pkg::GMASK_ADDR)
    begin
      // Group enables, other bits read zero.
      cur[gpc_pkg::GRP_LSB +: NP] = st.enable;
    end
    else if (io.addr == gpc_pkg::BBM_ADDR)
    begin
      // One break-before-make bit per port.
      cur[NP-1:0] = st.bbm;
    end
    else
    begin
      // Masks and port registers.
      for (int g = 0; g < NP; g++)
      begin
        if (io.addr == gpc_pkg::MASK_ADDR[g])
          cur = st.mask[g] & gpc_pkg::MASK_VALID[g];
        else if (io.addr[5:2] == gpc_pkg::PORT_BASE[g][5:2])
        begin
          // Four locations per port.
          if (io.addr[1:0] == gpc_pkg::OFS_PIN)
          begin
            cur = port_view[g].pin;
            w1_reg = 1'b1;
          end
          else if (io.addr[1:0] == gpc_pkg::OFS_DIR)
            cur = port_view[g].dir;
          else if (io.addr[1:0] == gpc_pkg::OFS_LATCH)
            cur = port_view[g].latch;
          else
            cur = port_view[g].pull;
        end
      end
    end
  end

  // Effective write data for full writes and bit operations.
  // A bit operation rewrites the byte with only one bit changed.
  // On write-one registers a set writes just the chosen bit and a clear writes zero, so no
  // other latch bit toggles and no other flag is cleared.
  always_comb
  begin
    bmask = 8'h01 << io.bit_sel;
    wr_any = io.wr | io.bit_set | io.bit_clr;
    if (io.wr)
      wd = io.wdata;
    else if (io.bit_set)
      wd = w1_reg ? bmask : (cur | bmask);
    else if (w1_reg)
      wd = 8'h00;
    else
      wd = cur & ~bmask;
  end

  // Write strobes toward each port.
  always_comb
  begin
    for (int g = 0; g < NP; g++)
    begin
      port_wr[g] = '0;
      port_wr[g].data = wd;
      if (wr_any && io.addr[5:2] == gpc_pkg::PORT_BASE[g][5:2])
      begin
        // Pin input writes toggle, the others load.
        if (io.addr[1:0] == gpc_pkg::OFS_PIN)
          port_wr[g].toggle_we = 1'b1;
        else if (io.addr[1:0] == gpc_pkg::OFS_DIR)
          port_wr[g].dir_we = 1'b1;
        else if (io.addr[1:0] == gpc_pkg::OFS_LATCH)
          port_wr[g].latch_we = 1'b1;
        else
          port_wr[g].pull_we = 1'b1;
      end
    end
  end

  // Next state of masks, enables, flags and the read answer.
  always_comb
  begin
    next_st = st;
    // Read data is captured on the read request.
    if (io.rd)
      next_st.rdata = cur;
    // Register writes.
    if (wr_any)
    begin
      if (io.addr == gpc_pkg::GMASK_ADDR)
        next_st.enable = wd[gpc_pkg::GRP_LSB +: NP];
      else if (io.addr == gpc_pkg::BBM_ADDR)
        next_st.bbm = wd[NP-1:0];
      for (int g = 0; g < NP; g++)
      begin
        // Reserved mask bits stay zero.
        if (io.addr == gpc_pkg::MASK_ADDR[g])
          next_st.mask[g] = wd & gpc_pkg::MASK_VALID[g];
      end
    end
    // Flags clear by a one written or by acknowledge; a new
    // change in the same clock wins over the clear.
    if (wr_any && io.addr == gpc_pkg::FLAG_ADDR)
      next_st.flag = st.flag & ~wd[gpc_pkg::GRP_LSB +: NP];
    next_st.flag = (next_st.flag & ~irq_ack) | hit;
    // Request stands while a flag and its enable are set.
    next_st.irq = next_st.flag & next_st.enable;
  end

  // Register the state.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  // One port and one change detector per group.
  // Group 0 is the low mask, 1 the mid, 2 the high.
  for (genvar g = 0; g < NP; g++)
  begin : g_port
    localparam int W = gpc_pkg::PORT_W[g];
    localparam int L = gpc_pkg::PORT_LSB[g];

    // Register bits and pin drivers.
    gpc_port #(
      .W (W)
    ) u_port (
      .sys_clk    (sys_clk),
      .arst_n     (arst_n),
      .wr         (port_wr[g]),
      .bbm        (st.bbm[g]),
      .pin_in     (pin_in[L +: W]),
      .view       (port_view[g]),
      .pin_out    (pin_out[L +: W]),
      .pin_oe     (pin_oe[L +: W]),
      .pin_pullup (pin_pullup[L +: W])
    );

    // Detection is gated by the mask and the group enable.
    gpc_chg #(
      .W (W)
    ) u_chg (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .pin_sync (port_view[g].pin[W-1:0]),
      .mask     (st.mask[g][W-1:0]),
      .enable   (st.enable[g]),
      .hit      (hit[g])
    );
  end

  // Outputs straight from registers.
  assign io_rdata   = st.rdata;
  assign change_irq = st.irq;

endmodule
`default_nettype wire

// ### tb/gpc_pins.sv
`timescale 1ns/1ps
`default_nettype none
// Board side of the pins: driver, outside source, pull-up or float.
module gpc_pins (
  input  wire logic        sys_clk,
  input  wire logic [17:0] pin_out,
  input  wire logic [17:0] pin_oe,
  input  wire logic [17:0] pin_pullup,
  input  wire logic [17:0] ext_val,
  input  wire logic [17:0] ext_en,
  output logic      [17:0] pin_in
);
  logic [17:0] flt = '0;  // A floating pin wanders every cycle.
  always @(posedge sys_clk) flt <= ~flt;
  // Own driver first, then outside source, then pull-up.
  always_comb
    for (int i = 0; i < 18; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
        pin_pullup[i] ? 1'b1 : flt[i];
endmodule
`default_nettype wire

// ### tb/gpc_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the GPIO block; sees only the top ports.
module gpc_props (
  input wire logic                      sys_clk,
  input wire logic                      arst_n,
  input wire gpc_pkg::gpc_io_req_t      io,
  input wire logic [gpc_pkg::NPORT-1:0] irq_ack,
  input wire logic [gpc_pkg::NPIN-1:0]  pin_in,
  input wire logic [7:0]                io_rdata,
  input wire logic [gpc_pkg::NPIN-1:0]  pin_out,
  input wire logic [gpc_pkg::NPIN-1:0]  pin_oe,
  input wire logic [gpc_pkg::NPIN-1:0]  pin_pullup,
  input wire logic [gpc_pkg::NPORT-1:0] change_irq
);
  // All checks run on the one system clock.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Reset alone must release every driver and pull-up.
  AST_RST_OFF: assert property (disable iff (1'b0) !arst_n |->
    pin_oe == '0 && pin_pullup == '0) else $error("pins active in reset");
  AST_MID_RSV: assert property (io.rd && io.addr == 6'h0A |=>
    io_rdata[7:4] == 4'h0) else $error("mid mask upper bits set");
  AST_PIN_RD: assert property (io.rd && io.addr == 6'h00 |=>
    io_rdata == $past(pin_in[7:0], 3)) else $error("pin read wrong");
  AST_TOGGLE: assert property (io.wr &&
    io.addr == 6'h00 |=>
    pin_out[7:0] == ($past(pin_out[7:0]) ^ $past(io.wdata)))
    else $error("toggle wrong");
  AST_LATCH: assert property (io.wr && io.addr == 6'h02 |=>
    pin_out[7:0] == $past(io.wdata)) else $error("latch wrong");
  AST_PULL: assert property (io.wr && io.addr == 6'h03 |=>
    pin_pullup[7:0] == $past(io.wdata)) else $error("pull-up wrong");
  AST_BIT_SET: assert property (io.bit_set && !io.wr &&
    io.addr == 6'h02 |=> pin_out[7:0] ==
    ($past(pin_out[7:0]) | (8'h01 << $past(io.bit_sel))))
    else $error("bit set wrong");
  AST_DIR: assert property (io.wr && io.addr == 6'h01 ##1
    !(io.wr || io.bit_set || io.bit_clr) |=>
    pin_oe[7:0] == $past(io.wdata, 2)) else $error("direction wrong");
  AST_NO_GAP: assert property (io.wr && io.addr == 6'h01 &&
    io.wdata == 8'h00 |=> pin_oe[7:0] == 8'h00)
    else $error("late release");
endmodule
bind gpc_top gpc_props i_gpc_props (.sys_clk(sys_clk), .arst_n(arst_n),
  .io(io), .irq_ack(irq_ack), .pin_in(pin_in), .io_rdata(io_rdata),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
  .change_irq(change_irq));
`default_nettype wire

// ### tb/test_gpio_port_with_pin_change_masks.sv
`timescale 1ns/1ps
`default_nettype none
// Random register traffic checked against a byte model of the block.
module test_gpio_port_with_pin_change_masks;
  logic sys_clk = 1'b0;
  logic arst_n;
  gpc_pkg::gpc_io_req_t io;
  logic [2:0]  irq_ack, change_irq;
  logic [17:0] pin_in, pin_out, pin_oe, pin_pullup, ext_val, ext_en;
  logic [7:0]  io_rdata;
  int          error_cnt = 0, tests_run = 0;
  logic [31:0] seed = 32'h4106;
  logic [7:0]  r [0:63];   // Model register file.
  logic [5:0]  tbl [0:18]; // Addresses visited by random ops.
  localparam logic [5:0] FL = gpc_pkg::FLAG_ADDR;

  gpc_top i_gpc_top (.sys_clk(sys_clk), .arst_n(arst_n), .io(io),
    .irq_ack(irq_ack), .pin_in(pin_in), .io_rdata(io_rdata),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .change_irq(change_irq));
  gpc_pins i_gpc_pins (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  initial forever #2.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Writable bits of an address.
  function automatic logic [7:0] wm(logic [5:0] a);
    wm = (a == gpc_pkg::GMASK_ADDR) ? 8'h70 :
      (a == gpc_pkg::BBM_ADDR) ? 8'h07 : 8'h00;
    for (int g = 0; g < 3; g++)
    begin
      if (a[5:2] == gpc_pkg::PORT_BASE[g][5:2] && a[1:0] != 2'h0)
        wm = 8'hFF >> (8 - gpc_pkg::PORT_W[g]);
      if (a == gpc_pkg::MASK_ADDR[g]) wm = gpc_pkg::MASK_VALID[g];
    end
  endfunction
  // One register of every port gathered into pin order.
  function automatic logic [17:0] vec(logic [1:0] o);
    for (int g = 0; g < 3; g++)
      for (int b = 0; b < gpc_pkg::PORT_W[g]; b++)
        vec[gpc_pkg::PORT_LSB[g]+b] = r[gpc_pkg::PORT_BASE[g]+o][b];
  endfunction
  function automatic logic [17:0] pinv();
    return (vec(2'h1) & vec(2'h2)) | (~vec(2'h1) & ext_val);
  endfunction
  function automatic logic [7:0] exp_rd(logic [5:0] a);
    exp_rd = r[a];
    for (int g = 0; g < 3; g++)
      if (a == gpc_pkg::PORT_BASE[g])
        exp_rd = 8'(pinv() >> gpc_pkg::PORT_LSB[g]) & wm(a + 6'h1);
  endfunction
  task automatic chk(string n, logic [17:0] e, logic [17:0] s);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One bus op (0 write, 1 set, 2 clear, 3 ack, 4 pins), then settle.
  task automatic op(int k, logic [5:0] a, logic [2:0] s, logic [7:0] d);
    logic [17:0]          pre;
    logic [7:0]           m, e;
    gpc_pkg::gpc_io_req_t q;
    pre = pinv();
    m = 8'h01 << s;
    e = (k == 0) ? d : (k == 1) ? m : 8'h00;
    // Build the request first so the bus changes once per edge.
    q = '0;
    q.addr = a;
    q.bit_sel = s;
    q.wdata = d;
    q.wr = (k == 0);
    q.bit_set = (k == 1);
    q.bit_clr = (k == 2);
    @(negedge sys_clk);
    io = q;
    irq_ack = (k == 3) ? d[2:0] : 3'h0;
    if (k == 4) ext_val = 18'(rnd());
    if (k == 3) r[FL] &= ~{1'b0, d[2:0], 4'h0};
    else if (a == FL) r[FL] &= ~e;
    else if (a[1:0] == 2'h0 && wm(a + 6'h1) != 8'h00)
      r[a+6'h2] ^= e & wm(a + 6'h1);
    else if (k < 3)
      r[a] = (k == 2) ? r[a] & ~m : (k == 1) ? r[a] | (m & wm(a)) :
        d & wm(a);
    @(negedge sys_clk);
    io = '0;
    irq_ack = 3'h0;
    repeat (4) @(negedge sys_clk);
    pre ^= pinv();
    for (int g = 0; g < 3; g++)
      if (|(8'(pre >> gpc_pkg::PORT_LSB[g]) & r[gpc_pkg::MASK_ADDR[g]])
          && r[gpc_pkg::GMASK_ADDR][4+g]) r[FL][4+g] = 1'b1;
  endtask
  task automatic rd(logic [5:0] a);
    gpc_pkg::gpc_io_req_t q;
    q = '0;
    q.rd = 1'b1;
    q.addr = a;
    @(negedge sys_clk);
    io = q;
    @(negedge sys_clk);
    io = '0;
    chk("rdata", 18'(exp_rd(a)), 18'(io_rdata));
  endtask

  // Watchdog: the tests need a few thousand cycles, this allows 20000.
  initial
  begin
    #100000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    io = '0;
    irq_ack = 3'h0;
    ext_val = '0;
    ext_en = '1;
    arst_n = 1'b0;
    for (int i = 0; i < 64; i++) r[i] = 8'h00;
    for (int g = 0; g < 3; g++)
      for (int j = 0; j < 4; j++) tbl[4*g+j] = gpc_pkg::PORT_BASE[g] + j;
    for (int g = 0; g < 3; g++) tbl[12+g] = gpc_pkg::MASK_ADDR[g];
    tbl[15] = FL;
    tbl[16] = gpc_pkg::GMASK_ADDR;
    tbl[17] = gpc_pkg::BBM_ADDR;
    tbl[18] = 6'h3F;
    repeat (6) @(negedge sys_clk);
    arst_n = 1'b1;
    // Break-before-make on port 0: one dark cycle, none on release.
    op(0, gpc_pkg::BBM_ADDR, 3'h0, 8'h01);
    io = '{wr: 1'b1, addr: 6'h01, wdata: 8'hFF, default: '0};
    @(negedge sys_clk);
    io = '0;
    chk("gap", 18'h0, pin_oe);
    @(negedge sys_clk);
    chk("drive", 18'hFF, pin_oe);
    repeat (2) @(negedge sys_clk);
    // The release goes back to the direction register, not the pins.
    io = '{wr: 1'b1, addr: 6'h01, wdata: 8'h00, default: '0};
    @(negedge sys_clk);
    io = '0;
    chk("release", 18'h0, pin_oe);
    $display("test break_before_make done");
    // Random traffic over every register and the pins.
    for (int n = 0; n < 400; n++)
    begin
      op(rnd() % 5, tbl[rnd() % 19], 3'(rnd()), 8'(rnd()));
      rd(tbl[rnd() % 19]);
      chk("oe", vec(2'h1), pin_oe);
      chk("out", vec(2'h2), pin_out);
      chk("pull", vec(2'h3), pin_pullup);
      chk("irq", 18'((r[FL] & r[gpc_pkg::GMASK_ADDR]) >> 4),
        18'(change_irq));
    end
    $display("test random_traffic done");
    // Drive and pull port 0, then reset without a clock edge: the
    // pins must let go at once.
    op(0, 6'h03, 3'h0, 8'hFF);
    op(0, 6'h01, 3'h0, 8'hFF);
    arst_n = 1'b0;
    #1;
    chk("reset_oe", 18'h0, pin_oe);
    chk("reset_pull", 18'h0, pin_pullup);
    chk("reset_out", 18'h0, pin_out);
    chk("reset_irq", 18'h0, 18'(change_irq));
    chk("reset_rdata", 18'h0, 18'(io_rdata));
    // Let one edge pass so the reset property sees the idle pins.
    @(negedge sys_clk);
    $display("test async_reset done");
    close_out();
  end
endmodule
`default_nettype wire
